// *** rtl/frdp_regs.svh ***
`ifndef FRDP_REGS_SVH
`define FRDP_REGS_SVH
// times in ns
`define FRDP_RESET_PULSE_MIN_NS      100
`define FRDP_RESET_DURING_OP_NS      25000
`define FRDP_POWER_VALID_RELEASE     300
`define FRDP_SLEEP_PULSE_MIN_NS      100
`define FRDP_SLEEP_EXIT_SELECT_NS    75000
`define FRDP_RESET_RELEASE_SELECT_NS 75000
`define FRDP_CLK_PERIOD_NS           25
// cycle counts: max times round down, min times round up
`define FRDP_RESET_PULSE_CYC ((`FRDP_RESET_PULSE_MIN_NS + \
  `FRDP_CLK_PERIOD_NS - 1) / `FRDP_CLK_PERIOD_NS)
`define FRDP_RESET_OP_CYC (`FRDP_RESET_DURING_OP_NS / `FRDP_CLK_PERIOD_NS)
`define FRDP_SLEEP_EXIT_CYC ((`FRDP_SLEEP_EXIT_SELECT_NS + \
  `FRDP_CLK_PERIOD_NS - 1) / `FRDP_CLK_PERIOD_NS)
// extended configuration field positions
`define FRDP_ECR_SLEEP_EN_BIT  15
`define FRDP_ECR_SLEEP_POL_BIT 14
// status values and auto-standby idle count
`define FRDP_STATUS_RESET  16'h0080
`define FRDP_STATUS_ERRMSK 16'h003A
`define FRDP_IDLE_CYC      4
`endif

// *** rtl/frdp_pkg.sv ***
package frdp_pkg;
  typedef enum logic [2:0] {
    FRDP_RESET   = 3'b000,
    FRDP_ACTIVE  = 3'b001,
    FRDP_STANDBY = 3'b010,
    FRDP_SLEEP   = 3'b011,
    FRDP_EXIT    = 3'b100
  } frdp_state_t;
endpackage : frdp_pkg

// *** rtl/frdp_counter.sv ***
`timescale 1ns/10ps
`default_nettype none
module frdp_counter #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  output logic                  done
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } frdp_cnt_t;
  frdp_cnt_t st;
  frdp_cnt_t next_st;
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.count = loadValue;
    end else if (st.count != '0) begin
      next_st.count = st.count - 1'b1;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign done = (st.count == '0) && !load;
endmodule : frdp_counter
`default_nettype wire

// *** rtl/frdp_ctrl.sv ***
// What this block does
// - reset during block erase completes within 25 us
// - reset during program completes within 25 us
// - reset while idle completes within minimum reset pulse time
// - after array read, quiet address puts device in standby automatically
// - deep sleep needs enable bit, reset and select idle, pin asserted
// - deep sleep aborts running program or erase, target becomes invalid
// - deep sleep discards a suspended operation; resume cannot continue it
// - in deep sleep only sleep pin and reset are heeded
// - deep sleep keeps read modes, configuration and lock bits
// - deep sleep sets status to 0080h, clearing error bits
// - releasing sleep pin returns to standby after exit delay
// - sleep pin is active low when polarity bit is 0
// - while reset low, inputs ignored, data and wait outputs off
// - leaving reset gives async array read, status 0080h
// - reset during program or erase aborts it, target invalid
`timescale 1ns/10ps
`default_nettype none
`include "frdp_regs.svh"
module frdp_ctrl #(
  parameter int EXIT_CYC  = `FRDP_SLEEP_EXIT_CYC,
  parameter int RSTOP_CYC = `FRDP_RESET_OP_CYC,
  parameter int CW        = 12
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        resetPin_n,
  input  wire logic        chipEnable_n,
  input  wire logic        deepSleepPin,
  input  wire logic [15:0] extendedConfigReg,
  input  wire logic        addrChange,
  input  wire logic        arrayReadDone,
  input  wire logic        programBusy,
  input  wire logic        eraseBusy,
  input  wire logic        opSuspended,
  input  wire logic        statusSet,
  input  wire logic [15:0] statusSetValue,
  output logic             resetDone,
  output logic             ready,
  output logic             standby,
  output logic             deepSleep,
  output logic             opAbort,
  output logic             suspendDiscard,
  output logic             outputsOff,
  output logic             asyncReadMode,
  output logic [15:0]      statusReg
);
  typedef struct packed {
    frdp_pkg::frdp_state_t state;
    logic [2:0]            idleCnt;
    logic                  resetDone;
    logic                  ready;
    logic                  standby;
    logic                  deepSleep;
    logic                  opAbort;
    logic                  suspendDiscard;
    logic                  outputsOff;
    logic                  asyncReadMode;
    logic [15:0]           statusReg;
  } frdp_ctrl_t;

  frdp_ctrl_t st;
  frdp_ctrl_t next_st;
  logic       cntLoad;
  logic [CW-1:0] cntValue;
  logic       cntDone;
  logic       sleepAsserted;
  logic       sleepWanted;
  logic       arrayBusy;

  // resetDone shows one edge after done, which rises as the count reaches zero, so loads are one short
  // to keep the reset finish inside its limit rather than one cycle past it
  localparam int RST_IDLE_LOAD = `FRDP_RESET_PULSE_CYC - 1;
  localparam int RST_BUSY_LOAD = RSTOP_CYC - 1;

  // the supply-valid hold before release is the host's; nothing here checks it
  // polarity bit chooses pin sense
  function automatic logic pinActive(input logic pin, input logic pol);
    pinActive = pol ? pin : !pin;
  endfunction : pinActive

  assign sleepAsserted = pinActive(deepSleepPin,
                                   extendedConfigReg[`FRDP_ECR_SLEEP_POL_BIT]);
  // entry needs all three at once; they may have arrived in any order
  assign sleepWanted = extendedConfigReg[`FRDP_ECR_SLEEP_EN_BIT]
                       && chipEnable_n && sleepAsserted;
  // program and erase abort alike, so one flag serves both
  assign arrayBusy = programBusy | eraseBusy;

  frdp_counter #(.WIDTH(CW)) frdp_counter_inst (
    .clk       (clk),
    .arst_n    (arst_n),
    .load      (cntLoad),
    .loadValue (cntValue),
    .done      (cntDone)
  );

  always_comb begin
    next_st = st;
    cntLoad = 1'b0;
    cntValue = '0;
    next_st.opAbort = 1'b0;
    next_st.suspendDiscard = 1'b0;
    if (!resetPin_n) begin
      // reset wins over everything, including deep sleep
      next_st.outputsOff = 1'b1;
      next_st.ready = 1'b0;
      next_st.standby = 1'b0;
      next_st.deepSleep = 1'b0;
      if (st.state != frdp_pkg::FRDP_RESET) begin
        // the array content at the aborted target is not repaired here
        next_st.opAbort = arrayBusy;
        next_st.resetDone = 1'b0;
        cntLoad = 1'b1;
        // busy array needs the long internal unwind, idle needs one pulse
        cntValue = arrayBusy ? CW'(RST_BUSY_LOAD)
                   : CW'(RST_IDLE_LOAD);
      end else if (cntDone) begin
        next_st.resetDone = 1'b1;
      end
      next_st.state = frdp_pkg::FRDP_RESET;
    end else begin
      case (st.state)
        frdp_pkg::FRDP_RESET: begin
          // release: read path back in async array mode with a clean status
          next_st.outputsOff = 1'b0;
          next_st.resetDone = 1'b1;
          next_st.asyncReadMode = 1'b1;
          next_st.statusReg = `FRDP_STATUS_RESET;
          next_st.ready = 1'b1;
          next_st.state = frdp_pkg::FRDP_ACTIVE;
        end
        frdp_pkg::FRDP_ACTIVE,
        frdp_pkg::FRDP_STANDBY: begin
          if (statusSet) begin
            next_st.statusReg = statusSetValue;
          end
          // a select ends the power-on async read default
          if (!chipEnable_n) begin
            next_st.asyncReadMode = 1'b0;
          end
          // auto standby: read done or deselected, and address lines quiet
          if (addrChange || !chipEnable_n && !arrayReadDone) begin
            next_st.idleCnt = '0;
            next_st.standby = 1'b0;
            next_st.state = frdp_pkg::FRDP_ACTIVE;
          end else if (st.idleCnt != 3'(`FRDP_IDLE_CYC)) begin
            next_st.idleCnt = st.idleCnt + 1'b1;
          end else begin
            next_st.standby = 1'b1;
            next_st.state = frdp_pkg::FRDP_STANDBY;
          end
          if (sleepWanted) begin
            next_st.opAbort = arrayBusy;
            next_st.suspendDiscard = opSuspended;
            // only status changes; configuration and modes held
            next_st.statusReg = (`FRDP_STATUS_RESET
                                 & ~`FRDP_STATUS_ERRMSK);
            next_st.deepSleep = 1'b1;
            next_st.ready = 1'b0;
            next_st.standby = 1'b0;
            next_st.state = frdp_pkg::FRDP_SLEEP;
          end
        end
        frdp_pkg::FRDP_SLEEP: begin
          // only sleep pin (and reset above) are looked at
          if (!sleepAsserted) begin
            next_st.deepSleep = 1'b0;
            cntLoad = 1'b1;
            cntValue = CW'(EXIT_CYC);
            next_st.state = frdp_pkg::FRDP_EXIT;
          end
        end
        frdp_pkg::FRDP_EXIT: begin
          // select is not watched here; the host owns the wait before it
          if (cntDone) begin
            next_st.ready = 1'b1;
            next_st.standby = 1'b1;
            next_st.idleCnt = 3'(`FRDP_IDLE_CYC);
            next_st.state = frdp_pkg::FRDP_STANDBY;
          end
        end
        default: begin
          // an illegal code falls back to the reset state
          next_st.state = frdp_pkg::FRDP_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{state: frdp_pkg::FRDP_RESET, idleCnt: 3'h0,
              resetDone: 1'b0, ready: 1'b0, standby: 1'b0,
              deepSleep: 1'b0, opAbort: 1'b0, suspendDiscard: 1'b0,
              outputsOff: 1'b1, asyncReadMode: 1'b1,
              statusReg: `FRDP_STATUS_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign resetDone      = st.resetDone;
  assign ready          = st.ready;
  assign standby        = st.standby;
  assign deepSleep      = st.deepSleep;
  assign opAbort        = st.opAbort;
  assign suspendDiscard = st.suspendDiscard;
  assign outputsOff     = st.outputsOff;
  assign asyncReadMode  = st.asyncReadMode;
  assign statusReg      = st.statusReg;
endmodule : frdp_ctrl
`default_nettype wire

// *** tb/frdp_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module frdp_chk #(
  parameter int EXIT_CYC  = 20,
  parameter int RSTOP_CYC = 10
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        resetPin_n,
  input wire logic        chipEnable_n,
  input wire logic        deepSleepPin,
  input wire logic        addrChange,
  input wire logic        arrayReadDone,
  input wire logic        programBusy,
  input wire logic        eraseBusy,
  input wire logic        opSuspended,
  input wire logic        resetDone,
  input wire logic        ready,
  input wire logic        standby,
  input wire logic        deepSleep,
  input wire logic        opAbort,
  input wire logic        suspendDiscard,
  input wire logic        outputsOff,
  input wire logic        asyncReadMode,
  input wire logic [15:0] extendedConfigReg,
  input wire logic [15:0] statusReg
);
  localparam int EXIT_HI = EXIT_CYC + 4;
  localparam int RST_HI  = RSTOP_CYC;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic pinOn = deepSleepPin == extendedConfigReg[14];
  wire logic cond = extendedConfigReg[15] && resetPin_n && chipEnable_n
    && pinOn;
  wire logic enter = cond && ready && !deepSleep;
  wire logic busy = programBusy || eraseBusy;
  sequence s_rstHeld; !resetPin_n [*6]; endsequence
  sequence s_exitWait; !ready [*8] ##[1:EXIT_HI] ready; endsequence
  sequence s_quiet;
    (ready && !deepSleep && !addrChange && arrayReadDone) [*6];
  endsequence
  property p_enter; enter |=> deepSleep; endproperty
  a_enter: assert property (p_enter) else $error("no sleep entry");
  property p_cause; $rose(deepSleep) |-> $past(cond); endproperty
  a_cause: assert property (p_cause) else $error("sleep uncaused");
  property p_abort; enter && busy |=> opAbort; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_discard; enter && opSuspended |=> suspendDiscard; endproperty
  a_discard: assert property (p_discard) else $error("no discard");
  property p_hold;
    deepSleep && $past(deepSleep) |-> statusReg == 16'h0080 && !ready;
  endproperty
  a_hold: assert property (p_hold) else $error("sleep state");
  property p_keepMode;
    deepSleep && $past(deepSleep) |-> $stable(asyncReadMode);
  endproperty
  a_keepMode: assert property (p_keepMode) else $error("mode lost");
  property p_exit;
    deepSleep && resetPin_n && !pinOn |=> !deepSleep ##0 s_exitWait;
  endproperty
  a_exit: assert property (p_exit) else $error("bad exit");
  property p_rstOff; !resetPin_n |=> outputsOff && !ready; endproperty
  a_rstOff: assert property (p_rstOff) else $error("outputs on");
  property p_rstBusy;
    $fell(resetPin_n) && busy |=> opAbort ##[0:RST_HI] (resetDone || resetPin_n);
  endproperty
  a_rstBusy: assert property (p_rstBusy) else $error("slow");
  property p_rstIdle; $fell(resetPin_n) && !busy ##0 s_rstHeld |-> resetDone;
  endproperty
  a_rstIdle: assert property (p_rstIdle) else $error("idle reset");
  property p_release; $rose(resetPin_n) |=> statusReg == 16'h0080; endproperty
  a_release: assert property (p_release) else $error("status");
  property p_standby; s_quiet |-> standby; endproperty
  a_standby: assert property (p_standby) else $error("no standby");
endmodule : frdp_chk
bind frdp_ctrl frdp_chk #(.EXIT_CYC(EXIT_CYC), .RSTOP_CYC(RSTOP_CYC))
  frdp_chk_inst (.clk, .arst_n, .resetPin_n, .chipEnable_n, .deepSleepPin,
  .addrChange, .arrayReadDone, .programBusy, .eraseBusy, .opSuspended,
  .resetDone, .ready, .standby, .deepSleep, .opAbort, .suspendDiscard,
  .outputsOff, .asyncReadMode, .extendedConfigReg, .statusReg);
`default_nettype wire

// *** tb/frdp_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module frdp_host #(
  parameter int EXIT_CYC = 20
) (
  input  wire logic clk,
  input  wire logic pol,
  output logic      resetPin_n,
  output logic      chipEnable_n,
  output logic      deepSleepPin
);
  initial begin
    resetPin_n = 1'b0; // held low through power-up
    chipEnable_n = 1'b1;
    deepSleepPin = 1'b1;
  end
  task automatic pulse_reset(input int n);
    @(posedge clk) #2 resetPin_n <= 1'b0;
    repeat (n) @(posedge clk); // n >= 4 keeps the pulse long
    #2 resetPin_n <= 1'b1;
  endtask : pulse_reset
  task automatic drive_select(input logic ce);
    @(posedge clk) #2 chipEnable_n <= ce;
  endtask : drive_select
  task automatic sleep_in();
    @(posedge clk) #2 chipEnable_n <= 1'b1;
    deepSleepPin <= !pol;
    @(posedge clk) #2 deepSleepPin <= pol; // held until sleep_out
  endtask : sleep_in
  task automatic sleep_out();
    @(posedge clk) #2 deepSleepPin <= !pol;
    repeat (EXIT_CYC + 4) @(posedge clk);
    #2 chipEnable_n <= 1'b0;
  endtask : sleep_out
endmodule : frdp_host
`default_nettype wire

// *** tb/frdp_ctrl_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module frdp_ctrl_tb;
  logic clk = 1'b0, arst_n = 1'b0, addrChange = 1'b0, arrayReadDone = 1'b0;
  logic programBusy = 1'b0, eraseBusy = 1'b0, opSuspended = 1'b0;
  logic statusSet = 1'b0, keptMode;
  logic [15:0] extendedConfigReg = 16'h8000, statusSetValue = 16'h003A;
  logic resetPin_n, chipEnable_n, deepSleepPin, resetDone, ready, standby;
  logic deepSleep, opAbort, suspendDiscard, outputsOff, asyncReadMode;
  logic [15:0] statusReg;
  int num_errors = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  frdp_host #(.EXIT_CYC(20)) frdp_host_inst (.clk,
    .pol(extendedConfigReg[14]), .resetPin_n, .chipEnable_n, .deepSleepPin);
  frdp_ctrl #(.EXIT_CYC(20), .RSTOP_CYC(10)) frdp_ctrl_inst (.clk, .arst_n,
    .resetPin_n, .chipEnable_n, .deepSleepPin, .extendedConfigReg,
    .addrChange, .arrayReadDone, .programBusy, .eraseBusy, .opSuspended,
    .statusSet, .statusSetValue, .resetDone, .ready, .standby, .deepSleep,
    .opAbort, .suspendDiscard, .outputsOff, .asyncReadMode, .statusReg);
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic chk(input string nm, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("mismatches %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    step(16);
    arst_n = 1'b1;
    frdp_host_inst.pulse_reset(12);
    step(3);
    chk("status", 16'h0080, statusReg);
    chk("mode", 16'h1, {15'h0, asyncReadMode});
    chk("outOff", 16'h0, {15'h0, outputsOff});
    frdp_host_inst.drive_select(1'b0);
    step(2);
    chk("reading", 16'h0, {15'h0, standby});
    arrayReadDone = 1'b1;
    addrChange = 1'b1;
    step(8);
    chk("addrBusy", 16'h0, {15'h0, standby});
    addrChange = 1'b0;
    step(8);
    chk("standby", 16'h1, {15'h0, standby});
    arrayReadDone = 1'b0;
    extendedConfigReg = 16'h0000;
    frdp_host_inst.sleep_in();
    step(4);
    chk("noSleep", 16'h0, {15'h0, deepSleep});
    extendedConfigReg = 16'h8000;
    step(2);
    chk("lateEn", 16'h1, {15'h0, deepSleep});
    frdp_host_inst.sleep_out();
    for (int p = 0; p < 2; p++) begin
      extendedConfigReg = {1'b1, p[0], 14'h0};
      statusSet = 1'b1;
      step(1);
      statusSet = 1'b0;
      keptMode = asyncReadMode;
      programBusy = 1'b1;
      opSuspended = 1'b1;
      frdp_host_inst.sleep_in();
      step(1);
      chk("abort", 16'h1, {15'h0, opAbort});
      chk("discard", 16'h1, {15'h0, suspendDiscard});
      step(2);
      chk("sleep", 16'h1, {15'h0, deepSleep});
      chk("sleepSt", 16'h0080, statusReg);
      programBusy = 1'b0;
      opSuspended = 1'b0;
      statusSet = 1'b1;
      addrChange = 1'b1;
      step(2);
      statusSet = 1'b0;
      addrChange = 1'b0;
      chk("ignored", 16'h0080, statusReg);
      frdp_host_inst.sleep_out();
      chk("ready", 16'h1, {15'h0, ready});
      chk("keep", {15'h0, keptMode}, {15'h0, asyncReadMode});
    end
    frdp_host_inst.sleep_in();
    step(3);
    frdp_host_inst.pulse_reset(8);
    step(2);
    chk("reEnter", 16'h1, {15'h0, deepSleep});
    frdp_host_inst.sleep_out();
    chk("ready2", 16'h1, {15'h0, ready});
    for (int k = 0; k < 3; k++) begin
      programBusy = (k == 0);
      eraseBusy = (k == 1);
      fork
        frdp_host_inst.pulse_reset(16);
        begin
          step(2);
          chk("rstAbort", (k < 2) ? 16'h1 : 16'h0, {15'h0, opAbort});
          step(12);
          chk("rstDone", 16'h1, {15'h0, resetDone});
          chk("rstOff", 16'h1, {15'h0, outputsOff});
        end
      join
      programBusy = 1'b0;
      eraseBusy = 1'b0;
      step(2);
      chk("rstSt", 16'h0080, statusReg);
    end
    wrap_up();
  end
endmodule : frdp_ctrl_tb
`default_nettype wire
